// ==== hdl/card_char_ctrl.sv ====
// card character data and control registers with a half-duplex character
// engine; assumes the data line arrives asynchronously to hclk
//
// Overview of operation
// - data writes ignored while receiving
// - data read gives char and parity flag
// - inverse: low is one, msb first
// - direct: low is zero, lsb first
// - sense and order are independent bits
// - parity selects: 0 even, 1 odd
// - receive error pulls line low when enabled
// - transmit checks for error when enabled
// - retry bounded by retry limit register
// - idle clock level bit sets stopped level
// - stop bit stops clock after delay
// - restart raises clock active after delay
// - sync card select bit sets mode
// - debounce prescale bypass bit
// - block guard timer enable bit
// - clock output driven or open drain
// - direction bit: 0 receive, 1 transmit
// - block timeout enable bit
// - answer duration timeout enable bit
// - unused upper bits read zero
//
// Chosen here: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module card_char_ctrl
    import card_char_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // card data line
    input wire logic data_line_in,
    output logic data_out_drive_n,
    // card clock
    output logic card_clock_out,
    output logic card_clock_oe,
    // settings and clock active interrupt for neighbouring blocks
    output intf_ctrl_t intf_settings,
    output logic clock_active_irq
);
    import card_char_pkg::*;

    // ----------------
    // registers
    // ----------------
    conv_ctrl_t conv;
    intf_ctrl_t intf;
    logic [11:0] clock_stop_delay;
    logic [11:0] clock_restart_delay;
    logic [5:0] retry_limit;
    logic [7:0] clock_div;
    logic [15:0] etu_div;
    logic [7:0] rx_char;
    logic rx_perr;
    logic [7:0] tx_char;
    logic tx_pending;
    logic tx_fail;

    // ----------------
    // bus slave: latch address phase, act in data phase
    // ----------------
    logic dp_wr;
    logic dp_rd;
    logic [11:0] dp_addr;
    logic addr_ok;
    assign addr_ok = hsel && hready && (htrans == htrans_nonseq)
        && (hsize == hsize_word);

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= 12'h000;
        end
        else
        begin
            dp_wr <= addr_ok && hwrite;
            dp_rd <= addr_ok && !hwrite;
            if (addr_ok)
                dp_addr <= {haddr[11:2], 2'b00};
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // card clock stop and restart events, character engine done pulses and received data
    logic stop_done;
    logic restart_done;
    logic tx_done_pulse;
    logic rx_done_pulse;
    logic [7:0] rx_shift_char;
    logic rx_shift_perr;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            conv <= conv_ctrl_t'(conv_reset);
            intf <= intf_ctrl_t'(intf_reset);
            clock_stop_delay <= delay_reset;
            clock_restart_delay <= delay_reset;
            retry_limit <= retry_reset;
            clock_div <= clock_div_reset;
            etu_div <= etu_div_reset;
        end
        else if (dp_wr)
        begin
            unique case (dp_addr)
                conv_ctrl_offset: conv <= conv_ctrl_t'(hwdata[7:0]);
                intf_ctrl_offset: intf <= intf_ctrl_t'(hwdata[6:0]);
                stop_delay_offset: clock_stop_delay <= hwdata[11:0];
                restart_delay_offset: clock_restart_delay <= hwdata[11:0];
                retry_limit_offset: retry_limit <= hwdata[5:0];
                clock_div_offset: clock_div <= hwdata[7:0];
                etu_div_offset: etu_div <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // tx holding register; receive direction drops data writes
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tx_char <= 8'h00;
            tx_pending <= 1'b0;
        end
        else if (dp_wr && dp_addr == char_data_offset && intf.dir_tx)
        begin
            tx_char <= hwdata[7:0];
            tx_pending <= 1'b1;
        end
        else if (tx_done_pulse)
            tx_pending <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_char <= 8'h00;
            rx_perr <= 1'b0;
        end
        else if (rx_done_pulse)
        begin
            rx_char <= rx_shift_char;
            rx_perr <= rx_shift_perr;
        end
    end

    logic engine_busy;
    logic clk_running;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (addr_ok && !hwrite)
        begin
            unique case ({haddr[11:2], 2'b00})
                char_data_offset:
                    hrdata <= {23'h00_0000, rx_perr, rx_char};
                conv_ctrl_offset: hrdata <= {24'h00_0000, conv};
                intf_ctrl_offset: hrdata <= {25'h000_0000, intf};
                stop_delay_offset: hrdata <= {20'h0_0000, clock_stop_delay};
                restart_delay_offset:
                    hrdata <= {20'h0_0000, clock_restart_delay};
                retry_limit_offset: hrdata <= {26'h000_0000, retry_limit};
                clock_div_offset: hrdata <= {24'h00_0000, clock_div};
                etu_div_offset: hrdata <= {16'h0000, etu_div};
                status_offset:
                    hrdata <= {28'h000_0000, tx_fail, tx_pending,
                        engine_busy, clk_running};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ----------------
    // card clock generator with stop and restart
    // ----------------
    logic [7:0] div_cnt;
    logic clk_level;
    logic clk_rise;
    logic [11:0] stop_cnt;
    logic stopped;
    logic restarting;
    assign clk_rise = (div_cnt == clock_div) && !clk_level && !stopped;
    assign stop_done = conv.clk_stop && !stopped
        && (stop_cnt >= clock_stop_delay) && clk_rise;
    assign restart_done = restarting && (stop_cnt >= clock_restart_delay)
        && clk_rise;
    assign clk_running = !stopped;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_cnt <= 8'h00;
            clk_level <= 1'b0;
            stop_cnt <= 12'h000;
            stopped <= 1'b0;
            restarting <= 1'b0;
        end
        else
        begin
            if (stopped)
            begin
                clk_level <= conv.clk_idle;
                div_cnt <= 8'h00;
                stop_cnt <= 12'h000;
                if (!conv.clk_stop)
                begin
                    stopped <= 1'b0;
                    restarting <= 1'b1;
                end
            end
            else if (div_cnt == clock_div)
            begin
                div_cnt <= 8'h00;
                clk_level <= !clk_level;
                if (stop_done)
                begin
                    stopped <= 1'b1;
                    clk_level <= conv.clk_idle;
                end
                else if (restart_done)
                    restarting <= 1'b0;
                if (clk_rise && (conv.clk_stop || restarting))
                    stop_cnt <= stop_cnt + 12'h001;
                else if (clk_rise)
                    stop_cnt <= 12'h000;
            end
            else
                div_cnt <= div_cnt + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            card_clock_out <= 1'b0;
            card_clock_oe <= 1'b1;
            clock_active_irq <= 1'b0;
            intf_settings <= intf_ctrl_t'(intf_reset);
        end
        else
        begin
            // open drain only ever drives low
            card_clock_out <= intf.open_drain ? 1'b0 : clk_level;
            card_clock_oe <= intf.open_drain ? !clk_level : 1'b1;
            clock_active_irq <= restart_done;
            intf_settings <= intf;
        end
    end

    // ----------------
    // character engine on the data line
    // ----------------
    logic din_meta;
    logic din;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            din_meta <= 1'b1;
            din <= 1'b1;
        end
        else
        begin
            din_meta <= data_line_in;
            din <= din_meta;
        end
    end

    char_state_t state;
    logic [15:0] etu_cnt;
    logic [3:0] bit_idx;
    logic [9:0] frame;
    logic [5:0] attempts;
    logic etu_tick;
    logic mid_tick;
    logic line_bit;
    logic [7:0] ordered;
    logic rx_parity_ok;
    // etu_div counts hclk per etu, so the tick ends the count one early
    assign etu_tick = (etu_cnt == etu_div - 16'h0001);
    assign mid_tick = (etu_cnt == {1'b0, etu_div[15:1]});
    // sense inverts level, order picks first bit
    assign line_bit = din ^ conv.sense;
    assign engine_busy = (state != st_idle);
    // parity bit is judged as it arrives, before it lands in frame
    assign rx_parity_ok = ((^frame[8:1]) ^ line_bit) == conv.rx_odd;
    assign rx_done_pulse = (state == st_rx) && mid_tick && bit_idx == 4'd9
        && (rx_parity_ok || !conv.rx_sig || attempts >= retry_limit);
    assign rx_shift_char = ordered;
    assign rx_shift_perr = !rx_parity_ok;
    assign tx_done_pulse = (state == st_tx_chk) && etu_tick
        && (din || !conv.tx_chk || attempts >= retry_limit);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_order
            assign ordered[gi] = conv.order ? frame[8 - gi] : frame[gi + 1];
        end
    endgenerate

    logic [7:0] tx_src;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_txord
            assign tx_src[gi] = conv.order ? tx_char[7 - gi] : tx_char[gi];
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state <= st_idle;
            etu_cnt <= 16'h0000;
            bit_idx <= 4'h0;
            frame <= 10'h000;
            attempts <= 6'h00;
            data_out_drive_n <= 1'b1;
            tx_fail <= 1'b0;
        end
        else
        begin
            etu_cnt <= etu_tick ? 16'h0000 : etu_cnt + 16'h0001;
            unique case (state)
                st_idle:
                begin
                    data_out_drive_n <= 1'b1;
                    etu_cnt <= 16'h0000;
                    bit_idx <= 4'h0;
                    if (intf.dir_tx && tx_pending)
                    begin
                        frame <= {(^tx_src) ^ conv.tx_odd, tx_src, 1'b0};
                        state <= st_tx;
                    end
                    else if (!intf.dir_tx && !din)
                        state <= st_rx;
                end
                st_rx:
                    if (mid_tick)
                    begin
                        frame[bit_idx] <= (bit_idx == 4'd0) ? din : line_bit;
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == 4'd9)
                        begin
                            if (rx_done_pulse)
                            begin
                                attempts <= 6'h00;
                                state <= st_guard;
                            end
                            else
                            begin
                                attempts <= attempts + 6'h01;
                                state <= st_rx_err;
                            end
                        end
                    end
                st_rx_err:
                    // wait out the parity bit, then pull low one etu
                    if (etu_tick)
                    begin
                        data_out_drive_n <= !data_out_drive_n;
                        if (!data_out_drive_n)
                            state <= st_guard;
                    end
                st_tx:
                    if (etu_tick)
                    begin
                        // drive low for a line zero, release for one
                        data_out_drive_n <= (bit_idx == 4'd0) ? 1'b0
                            : frame[bit_idx] ^ conv.sense;
                        bit_idx <= bit_idx + 4'h1;
                        if (bit_idx == 4'd10)
                        begin
                            data_out_drive_n <= 1'b1;
                            state <= st_tx_chk;
                        end
                    end
                st_tx_chk:
                    if (etu_tick)
                    begin
                        bit_idx <= 4'h0;
                        if (tx_done_pulse)
                        begin
                            tx_fail <= !din;
                            attempts <= 6'h00;
                            state <= st_guard;
                        end
                        else
                        begin
                            attempts <= attempts + 6'h01;
                            state <= st_tx;
                        end
                    end
                st_guard:
                    if (etu_tick)
                        state <= st_idle;
                default: state <= st_idle;
            endcase
        end
    end
endmodule : card_char_ctrl
`default_nettype wire

// ==== inc/card_char_pkg.sv ====
// constants, register map and carrier types of the card character block
// assumes a 32-bit ahb-lite register bus and a 200 MHz hclk
package card_char_pkg;
    // ----------------
    // register map
    // ----------------
    localparam logic [11:0] char_data_offset = 12'h000;
    localparam logic [11:0] conv_ctrl_offset = 12'h004;
    localparam logic [11:0] intf_ctrl_offset = 12'h008;
    localparam logic [11:0] stop_delay_offset = 12'h038;
    localparam logic [11:0] restart_delay_offset = 12'h03C;
    localparam logic [11:0] retry_limit_offset = 12'h040;
    localparam logic [11:0] clock_div_offset = 12'h010;
    localparam logic [11:0] etu_div_offset = 12'h018;
    localparam logic [11:0] status_offset = 12'h090;
    // ----------------
    // field positions
    // ----------------
    localparam int sense_bit = 0;
    localparam int order_bit = 1;
    localparam int tx_odd_bit = 2;
    localparam int tx_chk_bit = 3;
    localparam int rx_odd_bit = 4;
    localparam int rx_sig_bit = 5;
    localparam int clk_stop_bit = 6;
    localparam int clk_idle_bit = 7;
    localparam int atr_to_bit = 0;
    localparam int blk_to_bit = 1;
    localparam int dir_bit = 2;
    localparam int open_drain_bit = 3;
    localparam int bgt_bit = 4;
    localparam int dbnc_bit = 5;
    localparam int sync_bit = 6;
    localparam int parity_err_bit = 8;
    // ----------------
    // reset values and widths
    // ----------------
    localparam logic [7:0] conv_reset = 8'h00;
    localparam logic [6:0] intf_reset = 7'h00;
    localparam logic [11:0] delay_reset = 12'h000;
    localparam logic [5:0] retry_reset = 6'h00;
    localparam logic [7:0] clock_div_reset = 8'h00;
    localparam logic [15:0] etu_div_reset = 16'h0010;
    localparam logic [1:0] htrans_nonseq = 2'b10;
    localparam logic [2:0] hsize_word = 3'b010;
    // error signal on the line lasts about one etu
    localparam int err_etu_len = 1;

    typedef struct packed {
        logic clk_idle;
        logic clk_stop;
        logic rx_sig;
        logic rx_odd;
        logic tx_chk;
        logic tx_odd;
        logic order;
        logic sense;
    } conv_ctrl_t;

    typedef struct packed {
        logic sync_card;
        logic dbnc_bypass;
        logic bgt_en;
        logic open_drain;
        logic dir_tx;
        logic blk_to_en;
        logic atr_to_en;
    } intf_ctrl_t;

    typedef enum logic [5:0] {
        st_idle = 6'b000001,
        st_rx = 6'b000010,
        st_rx_err = 6'b000100,
        st_tx = 6'b001000,
        st_tx_chk = 6'b010000,
        st_guard = 6'b100000
    } char_state_t;
endpackage : card_char_pkg

// ==== verif/card_char_checker.sv ====
// port-level assertions for the card character block
// assumes it is bound to card_char_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module card_char_checker
    import card_char_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // register bus
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // card side
    input wire logic card_clock_out,
    input wire logic card_clock_oe,
    input wire intf_ctrl_t intf_settings,
    input wire logic clock_active_irq
);
    logic ok_q, wr_q, bad_q;
    logic [11:0] a_q;
    // ----------------
    // data phase tracking
    // ----------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ok_q <= 1'b0;
            wr_q <= 1'b0;
            bad_q <= 1'b0;
            a_q <= 12'h000;
        end
        else
        begin
            ok_q <= hsel && hready && htrans == htrans_nonseq
                && hsize == hsize_word;
            bad_q <= hsel && hready && hwrite && hsize != hsize_word;
            wr_q <= hwrite;
            a_q <= haddr;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ----------------
    // properties
    // ----------------
    zero_wait_a: assert property (hreadyout)
        else $error("wait state");
    okay_resp_a: assert property (!hresp)
        else $error("error response");
    // settings copy lags the register by one cycle
    intf_write_a: assert property (ok_q && wr_q
        && a_q == intf_ctrl_offset
        |-> ##2 intf_settings == $past(hwdata[6:0], 2))
        else $error("intf not written");
    bad_size_a: assert property (bad_q |-> ##2 $stable(intf_settings))
        else $error("byte write taken");
    upper_zero_a: assert property (ok_q && !wr_q && (a_q == conv_ctrl_offset
        || a_q == intf_ctrl_offset) |-> hrdata[31:8] == 24'h00_0000)
        else $error("upper bits set");
    unmapped_zero_a: assert property (ok_q && !wr_q
        && a_q == 12'h080 |-> hrdata == 32'h0000_0000)
        else $error("unmapped nonzero");
    intf_read_a: assert property (ok_q && !wr_q
        && a_q == intf_ctrl_offset |-> hrdata[6:0] == intf_settings)
        else $error("intf read wrong");
    irq_pulse_a: assert property (clock_active_irq |=> !clock_active_irq)
        else $error("irq too long");
    od_low_a: assert property (intf_settings.open_drain[*3]
        |-> !card_clock_out)
        else $error("clock drove high");
    buf_oe_a: assert property (!intf_settings.open_drain[*3]
        |-> card_clock_oe)
        else $error("clock not driven");
endmodule : card_char_checker
bind card_char_ctrl card_char_checker i_checker (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .card_clock_out,
    .card_clock_oe, .intf_settings, .clock_active_irq
);
`default_nettype wire

// ==== verif/card_model.sv ====
// behavioural card on the half-duplex data line
// assumes one etu is etu_len hclk cycles and the line has a pull-up
`timescale 1ns/1ps
`default_nettype none
module card_model #(
    parameter int etu_len = 16
) (
    // clock
    input wire logic hclk,
    // data line
    input wire logic line,
    output logic card_low
);
    initial card_low = 1'b0;
    // bits[0] goes first after the start bit, bits[8] is parity
    task automatic send(input logic [8:0] bits, output logic err);
        err = 1'b0;
        card_low <= 1'b1;
        repeat (etu_len) @(posedge hclk);
        for (int i = 0; i < 9; i++)
        begin
            card_low <= ~bits[i];
            repeat (etu_len) @(posedge hclk);
        end
        card_low <= 1'b0;
        // the device may signal a parity error during guard time
        repeat (3 * etu_len) @(posedge hclk) if (line === 1'b0) err = 1'b1;
    endtask : send
    task automatic capture(output logic [8:0] bits, output logic seen);
        int n;
        n = 0;
        bits = 9'h000;
        seen = 1'b0;
        while (line !== 1'b0 && n < 4000) @(posedge hclk) n++;
        if (line === 1'b0)
        begin
            seen = 1'b1;
            // sample each bit near its middle
            repeat (etu_len / 2) @(posedge hclk);
            for (int i = 0; i < 9; i++)
            begin
                repeat (etu_len) @(posedge hclk);
                bits[i] = line;
            end
        end
    endtask : capture
endmodule : card_model
`default_nettype wire

// ==== verif/test_smart_card_char_control_regs.sv ====
// bench for the card character block with a behavioural card
// assumes the reset etu of 16 hclk and a card clock divider of 0
`timescale 1ns/1ps
`default_nettype none
module test_smart_card_char_control_regs;
    import card_char_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [2:0] hsize = hsize_word;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic hreadyout, hresp, data_out_drive_n, card_low;
    logic card_clock_out, card_clock_oe, clock_active_irq;
    intf_ctrl_t intf_settings;
    wire logic line;
    int n_mismatch = 0;
    int check_count = 0;
    // pull-up: high unless either party pulls low
    assign line = data_out_drive_n & ~card_low;
    always #2.5 hclk = ~hclk;
    card_char_ctrl i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .data_line_in(line),
        .data_out_drive_n(data_out_drive_n),
        .card_clock_out(card_clock_out), .card_clock_oe(card_clock_oe),
        .intf_settings(intf_settings), .clock_active_irq(clock_active_irq)
    );
    card_model #(.etu_len(16)) i_card (
        .hclk(hclk), .line(line), .card_low(card_low)
    );
    // ----------------
    // helpers
    // ----------------
    task automatic chk(input string what, input logic [31:0] got,
        input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic bus(input logic [11:0] a, input logic w,
        input logic [2:0] sz, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= htrans_nonseq;
        hwrite <= w;
        hsize <= sz;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(a, 1'b1, hsize_word, d, r);
    endtask : wr
    task automatic rchk(input string what, input logic [11:0] a,
        input logic [31:0] exp);
        logic [31:0] r;
        bus(a, 1'b0, hsize_word, 32'h0000_0000, r);
        chk(what, r, exp);
    endtask : rchk
    // expected line levels, first bit at index 0, parity at 8
    function automatic logic [8:0] line_bits(input logic [7:0] c,
        input logic odd, input logic sense, input logic order);
        logic [7:0] o;
        for (int i = 0; i < 8; i++)
            o[i] = order ? c[7 - i] : c[i];
        return {^c ^ odd, o} ^ {9{sense}};
    endfunction : line_bits
    initial
    begin
        repeat (50000) @(posedge hclk);
        n_mismatch++;
        test_done();
    end
    // ----------------
    // tests
    // ----------------
    initial
    begin
        logic [31:0] r;
        logic [8:0] b;
        logic e;
        logic [7:0] c;
        int n;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk("drive_n", data_out_drive_n, 1);
        rchk("conv", conv_ctrl_offset, 0);
        rchk("intf", intf_ctrl_offset, 0);
        wr(intf_ctrl_offset, 32'hFFFF_FFFF);
        rchk("intf", intf_ctrl_offset, 32'h7F);
        wr(conv_ctrl_offset, 32'hFFFF_FF3F);
        rchk("conv", conv_ctrl_offset, 32'h3F);
        for (int i = 0; i < 7; i++)
        begin
            wr(intf_ctrl_offset, 32'h1 << i);
            repeat (2) @(posedge hclk);
            chk("settings", intf_settings, 32'h1 << i);
            rchk("intf", intf_ctrl_offset, 32'h1 << i);
        end
        bus(intf_ctrl_offset, 1'b1, 3'b000, 32'h0000_0001, r);
        repeat (2) @(posedge hclk);
        chk("byte write", intf_settings, 32'h40);
        rchk("unmapped", 12'h080, 0);
        // transmit under every sense, order and parity choice
        wr(intf_ctrl_offset, 32'h0000_0004);
        for (int k = 0; k < 8; k++)
        begin
            c = 8'h3A + 8'(k * 37);
            wr(conv_ctrl_offset, 32'(k));
            fork
                i_card.capture(b, e);
                wr(char_data_offset, {24'h00_0000, c});
            join
            chk("tx seen", e, 1);
            chk("tx bits", b, line_bits(c, k[2], k[0], k[1]));
            repeat (64) @(posedge hclk);
        end
        // writes while receiving are dropped
        wr(intf_ctrl_offset, 32'h0000_0000);
        fork
            i_card.capture(b, e);
            wr(char_data_offset, 32'h0000_0055);
        join
        chk("rx mode tx", e, 0);
        // receive, good and bad parity, no error signalling
        for (int k = 0; k < 8; k++)
        begin
            c = 8'hC5 + 8'(k * 29);
            wr(conv_ctrl_offset, {27'h0, k[2], 2'b00, k[1:0]});
            i_card.send(line_bits(c, k[2], k[0], k[1]), e);
            rchk("rx good", char_data_offset, {24'h0, c});
            chk("no signal", e, 0);
            i_card.send(line_bits(c, k[2], k[0], k[1]) ^ 9'h100, e);
            rchk("rx bad", char_data_offset, {23'h0, 1'b1, c});
            chk("no signal", e, 0);
        end
        wr(retry_limit_offset, 32'h0000_0003);
        wr(conv_ctrl_offset, 32'h0000_0020);
        i_card.send(line_bits(8'h6B, 1'b0, 1'b0, 1'b0) ^ 9'h100, e);
        chk("error signal", e, 1);
        repeat (200) @(posedge hclk);
        // clock stop at both idle levels, then restart
        wr(stop_delay_offset, 32'h0000_0004);
        wr(restart_delay_offset, 32'h0000_0004);
        for (int v = 0; v < 2; v++)
        begin
            wr(conv_ctrl_offset, {24'h0, v[0], 7'h40});
            repeat (200) @(posedge hclk);
            n = 0;
            repeat (20) @(posedge hclk) n += int'(card_clock_out !== v[0]);
            chk("stopped clock", n, 0);
            wr(conv_ctrl_offset, {24'h0, v[0], 7'h00});
            n = 0;
            while (clock_active_irq !== 1'b1 && n < 400) @(posedge hclk) n++;
            chk("restart irq", n < 400, 1);
            n = 0;
            repeat (20) @(posedge hclk) n += int'(card_clock_out !== v[0]);
            chk("clock runs", n > 0, 1);
        end
        wr(intf_ctrl_offset, 32'h0000_0008);
        repeat (20) @(posedge hclk);
        chk("open drain", card_clock_out, 0);
        test_done();
    end
endmodule : test_smart_card_char_control_regs
`default_nettype wire
